// [hdl/hpp_consts.svh]
// Constants for the parallel host register port
`ifndef HPP_CONSTS_SVH
`define HPP_CONSTS_SVH
`define HPP_ADDR_W 8
`define HPP_LANE_W 8
`define HPP_QUAD_W 32
`define HPP_REG_WORDS 64
`define HPP_WAIT_CYCLES 2
`define HPP_WAIT_CNT_W 4
`endif

// [hdl/hpp_pkg.sv]
// Types for the parallel host register port
package hpp_pkg;
    typedef logic [7:0] lane_t;
    typedef logic [31:0] quad_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_SETUP = 3'b010,
        ST_STROBE = 3'b011,
        ST_HOLD = 3'b100
    } host_st_e;
endpackage

// [hdl/hpp_if.sv]
// Interface joining the host and the device ends of the parallel port
`timescale 1ns/1ps
`default_nettype none
interface hpp_if;
    // Straps
    logic width_select_strap;
    logic multiplex_select_strap;
    // Control from host
    logic chip_select_n;
    logic write_strobe_n;
    logic read_strobe_n;
    logic address_latch_strobe;
    logic quadlet_boundary_flag;
    logic [7:0] host_address_bus;
    // Data lanes; the device enable alone picks the device or the host values
    logic [7:0] host_low_data_lanes_h;
    logic [7:0] host_high_data_lanes_h;
    logic host_data_oe_h;
    logic [7:0] host_low_data_lanes_d;
    logic [7:0] host_high_data_lanes_d;
    logic host_data_oe_d;
    // Device outputs
    logic cycle_wait_out;
    logic interrupt_out_n_o;
    logic interrupt_out_n_oe;
    wire [7:0] low_lanes = host_data_oe_d ? host_low_data_lanes_d : host_low_data_lanes_h;
    wire [7:0] high_lanes = host_data_oe_d ? host_high_data_lanes_d : host_high_data_lanes_h;
    wire interrupt_line_n = interrupt_out_n_oe ? interrupt_out_n_o : 1'b1;
    modport device (
        input width_select_strap, multiplex_select_strap, chip_select_n, write_strobe_n,
        input read_strobe_n, address_latch_strobe, quadlet_boundary_flag, host_address_bus,
        input low_lanes, high_lanes,
        output host_low_data_lanes_d, host_high_data_lanes_d, host_data_oe_d,
        output cycle_wait_out, interrupt_out_n_o, interrupt_out_n_oe
    );
    modport host (
        output width_select_strap, multiplex_select_strap, chip_select_n, write_strobe_n,
        output read_strobe_n, address_latch_strobe, quadlet_boundary_flag, host_address_bus,
        output host_low_data_lanes_h, host_high_data_lanes_h, host_data_oe_h,
        input low_lanes, high_lanes, cycle_wait_out, interrupt_line_n
    );
endinterface
`default_nettype wire

// [hdl/hpp_device.sv]
// Device end of the parallel host register port with a quadlet register store
`include "hpp_consts.svh"
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Overview of operation
// - Width strap picks 8 or 16 bit path
// - High lanes used only in 16-bit mode
// - Mux strap shares address with low lanes
// - Latch strobe ignored when not multiplexed
// - Boundary flag triggers quadlet fetch or store
// - Access only while chip select low
// - Write strobe low with select writes
// - Read strobe low with select reads
// - Both strobes low counts as write
// - Interrupt pin pulled low while pending
// - Wait high while cycle is held
// - Master reset clears device control state asynchronously, not the store
module hpp_device #(
    parameter int WAIT_CYCLES = `HPP_WAIT_CYCLES,
    parameter int REG_WORDS = `HPP_REG_WORDS
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic master_reset_n_i,
    // Host port
    hpp_if.device bus,
    // Internal interrupt sources and status
    input wire logic [7:0] irq_src_i,
    output logic irq_pending_o,
    output logic [`HPP_ADDR_W-1:0] last_addr_o
);
    // =================================================================
    // Cycle walk, as seen from the device pins
    //   edge 0: chip select low with one strobe low is sampled; wait rises
    //   edges 1..WAIT_CYCLES-1: wait stays high while the counter runs
    //   edge WAIT_CYCLES: wait falls; read data is driven, write data taken
    //   later edges: access is done, nothing new starts until strobes rise
    // The lanes stay driven for a read until both strobes are high again,
    // which keeps the data valid for a host that samples late.
    // Write data is sampled at the finishing edge, so the host must keep it
    // on the lanes for the whole wait.
    // WAIT_CYCLES sets the wait length; any value from 1 up to 16 works,
    // and the host simply follows the pin.
    //
    // Quadlet assembly
    //   8-bit mode: four bytes, most significant first
    //   16-bit mode: two words, high lanes carry the upper byte of each word
    //   The boundary flag on the last write piece commits the quadlet; on
    //   the first read piece it loads the quadlet into the read shifter.
    //   Word 3f holds the interrupt flags; writing ones there clears them.
    //
    // Trade-off: one register word per quadlet keeps the store simple, but
    // the low two address bits are ignored, so byte addressing inside a
    // quadlet is not possible.
    //
    // Reset
    //   The master reset acts without a clock: wait, lane enable and the
    //   interrupt enable all fall at once, so the host sees a quiet port.
    //   The register store itself is not cleared; software must write it.
    //
    // Straps
    //   The straps are read live on every edge. Changing them in the middle
    //   of an access mixes two formats in one quadlet, so the system must
    //   only change them while chip select is high.
    //   With the multiplex strap low the latch strobe has no effect at all,
    //   and the latched address keeps whatever it held before.
    //
    // Both strobes low
    //   A write wins, so a host with one direction line can tie the read
    //   strobe low and drive the write strobe with that line.
    //
    // =================================================================
    // Strobe decode
    // Strobes qualify only with chip select; a read also needs write high
    wire sel = !bus.chip_select_n;
    wire wr_req = sel && !bus.write_strobe_n;
    wire rd_req = sel && !bus.read_strobe_n && bus.write_strobe_n;
    wire wide = bus.width_select_strap;
    wire latch_en = bus.multiplex_select_strap && bus.address_latch_strobe;

    // Address and quadlet state
    logic [7:0] addr_lat_q;
    logic [31:0] regs_q [REG_WORDS];
    logic [31:0] wr_shift_q;
    logic [31:0] rd_shift_q;
    logic [`HPP_WAIT_CNT_W-1:0] wait_cnt_q;
    logic busy_q;
    logic done_q;
    logic [7:0] irq_flags_q;
    logic [7:0] irq_flags_d;
    // Pin drivers
    logic [7:0] low_out_q;
    logic [7:0] high_out_q;
    logic oe_q;
    logic wait_q;
    logic irq_oe_q;
    logic [7:0] last_addr_q;

    // Address in use: the latched copy in multiplexed mode, the pins otherwise
    wire [7:0] addr_now = bus.multiplex_select_strap ? addr_lat_q : bus.host_address_bus;

    wire [5:0] word_idx = addr_now[7:2];
    wire start = (wr_req || rd_req) && !busy_q && !done_q;
    wire finish = busy_q && (wait_cnt_q == `HPP_WAIT_CNT_W'(WAIT_CYCLES - 1));
    wire [31:0] wr_word = wide ? {wr_shift_q[15:0], bus.high_lanes, bus.low_lanes}
                               : {wr_shift_q[23:0], bus.low_lanes};
    wire [31:0] fetched = (word_idx == 6'h3f) ? {24'h000000, irq_flags_q} : regs_q[word_idx];
    wire [31:0] rd_src = bus.quadlet_boundary_flag ? fetched : rd_shift_q;
    wire [31:0] rd_next = wide ? {rd_src[15:0], 16'h0000} : {rd_src[23:0], 8'h00};

    // Read lanes: the most significant piece of the quadlet goes out first
    wire [7:0] rd_low = wide ? rd_src[23:16] : rd_src[31:24];
    wire [7:0] rd_high = wide ? rd_src[31:24] : 8'h00;
    wire irq_clear = finish && wr_req && bus.quadlet_boundary_flag && (word_idx == 6'h3f);

    // =================================================================
    // Address latch and access sequencing
    // Done blocks a second access until the host releases the strobes,
    // so a strobe that is held low is never taken twice
    always_ff @(posedge clk_sys_i or negedge master_reset_n_i) begin
        if (!master_reset_n_i) begin
            addr_lat_q <= 8'h00;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            wait_cnt_q <= '0;
            wait_q <= 1'b0;
            wr_shift_q <= 32'h00000000;
            rd_shift_q <= 32'h00000000;
            low_out_q <= 8'h00;
            high_out_q <= 8'h00;
            oe_q <= 1'b0;
            last_addr_q <= 8'h00;
        end else begin
            if (latch_en) begin
                addr_lat_q <= bus.low_lanes;
            end
            if (start) begin
                busy_q <= 1'b1;
                wait_q <= 1'b1;
                wait_cnt_q <= '0;
            end else if (finish) begin
                busy_q <= 1'b0;
                done_q <= 1'b1;
                wait_q <= 1'b0;
                last_addr_q <= addr_now;
                if (wr_req) begin
                    wr_shift_q <= wr_word;
                end else begin
                    low_out_q <= rd_low;
                    high_out_q <= rd_high;
                    rd_shift_q <= rd_next;
                    oe_q <= 1'b1;
                end
            end else if (busy_q) begin
                wait_cnt_q <= wait_cnt_q + 1'b1;
            end
            if (!wr_req && !rd_req) begin
                done_q <= 1'b0;
                oe_q <= 1'b0;
            end
        end
    end

    // =================================================================
    // Quadlet store: written only when the boundary flag marks the last piece
    // No reset: contents are undefined until written, like a RAM
    always_ff @(posedge clk_sys_i) begin
        if (finish && wr_req && bus.quadlet_boundary_flag && word_idx != 6'h3f) begin
            regs_q[word_idx] <= wr_word;
        end
    end

    // =================================================================
    // Interrupt flags, one sticky flag per source bit; a new event wins
    // over a clear in the same cycle, so no event is ever lost
    for (genvar b = 0; b < 8; b++) begin : g_irq_flag
        assign irq_flags_d[b] = irq_src_i[b] || (irq_flags_q[b] && !(irq_clear && wr_word[b]));
    end

    // Pin enable follows the flags one cycle later
    always_ff @(posedge clk_sys_i or negedge master_reset_n_i) begin
        if (!master_reset_n_i) begin
            irq_flags_q <= 8'h00;
            irq_oe_q <= 1'b0;
        end else begin
            irq_flags_q <= irq_flags_d;
            irq_oe_q <= |irq_flags_q;
        end
    end

    // =================================================================
    // Pin drive
    assign bus.host_low_data_lanes_d = low_out_q;
    assign bus.host_high_data_lanes_d = high_out_q;
    assign bus.host_data_oe_d = oe_q;
    assign bus.cycle_wait_out = wait_q;
    assign bus.interrupt_out_n_o = 1'b0;
    assign bus.interrupt_out_n_oe = irq_oe_q;
    assign irq_pending_o = irq_oe_q;
    assign last_addr_o = last_addr_q;
endmodule
`default_nettype wire

// [hdl/hpp_host.sv]
// Host end of the parallel host register port, one access per command
`include "hpp_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module hpp_host (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // Straps chosen by the system
    input wire logic wide_i,
    input wire logic mux_i,
    // Command port
    input wire logic cmd_valid_i,
    input wire logic cmd_write_i,
    input wire logic cmd_boundary_i,
    input wire logic [7:0] cmd_addr_i,
    input wire logic [15:0] cmd_wdata_i,
    output logic cmd_ready_o,
    output logic rsp_valid_o,
    output logic [15:0] rsp_rdata_o,
    output logic irq_n_o,
    // Link
    hpp_if.host bus
);
    hpp_pkg::host_st_e st_q;
    logic cs_n_q, wr_n_q, rd_n_q, ale_q, flag_q, oe_q, ready_q, rsp_q, irq_q;
    logic [7:0] addr_q, low_q, high_q;
    logic [15:0] rdata_q;
    logic write_q;
    wire wait_seen = bus.cycle_wait_out;

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            st_q <= hpp_pkg::ST_IDLE;
            cs_n_q <= 1'b1;
            wr_n_q <= 1'b1;
            rd_n_q <= 1'b1;
            ale_q <= 1'b0;
            flag_q <= 1'b0;
            oe_q <= 1'b0;
            ready_q <= 1'b0;
            rsp_q <= 1'b0;
            irq_q <= 1'b1;
            addr_q <= 8'h00;
            low_q <= 8'h00;
            high_q <= 8'h00;
            rdata_q <= 16'h0000;
            write_q <= 1'b0;
        end else begin
            irq_q <= bus.interrupt_line_n;
            rsp_q <= 1'b0;
            unique case (st_q)
                hpp_pkg::ST_IDLE: begin
                    ready_q <= 1'b1;
                    if (cmd_valid_i && ready_q) begin
                        ready_q <= 1'b0;
                        write_q <= cmd_write_i;
                        flag_q <= cmd_boundary_i;
                        addr_q <= cmd_addr_i;
                        low_q <= mux_i ? cmd_addr_i : cmd_wdata_i[7:0];
                        high_q <= wide_i ? cmd_wdata_i[15:8] : 8'h00;
                        oe_q <= cmd_write_i || mux_i;
                        ale_q <= mux_i;
                        cs_n_q <= 1'b0;
                        st_q <= mux_i ? hpp_pkg::ST_ADDR : hpp_pkg::ST_SETUP;
                    end
                end
                hpp_pkg::ST_ADDR: begin
                    ale_q <= 1'b0;
                    low_q <= cmd_wdata_i[7:0];
                    oe_q <= write_q;
                    st_q <= hpp_pkg::ST_SETUP;
                end
                hpp_pkg::ST_SETUP: begin
                    wr_n_q <= !write_q;
                    rd_n_q <= write_q;
                    st_q <= hpp_pkg::ST_STROBE;
                end
                hpp_pkg::ST_STROBE: begin
                    st_q <= hpp_pkg::ST_HOLD;
                end
                hpp_pkg::ST_HOLD: begin
                    if (!wait_seen) begin
                        rdata_q <= {wide_i ? bus.high_lanes : 8'h00, bus.low_lanes};
                        rsp_q <= 1'b1;
                        wr_n_q <= 1'b1;
                        rd_n_q <= 1'b1;
                        cs_n_q <= 1'b1;
                        oe_q <= 1'b0;
                        st_q <= hpp_pkg::ST_IDLE;
                    end
                end
                default: begin
                    st_q <= hpp_pkg::ST_IDLE;
                end
            endcase
        end
    end

    assign bus.width_select_strap = wide_i;
    assign bus.multiplex_select_strap = mux_i;
    assign bus.chip_select_n = cs_n_q;
    assign bus.write_strobe_n = wr_n_q;
    assign bus.read_strobe_n = rd_n_q;
    assign bus.address_latch_strobe = ale_q;
    assign bus.quadlet_boundary_flag = flag_q;
    assign bus.host_address_bus = addr_q;
    assign bus.host_low_data_lanes_h = low_q;
    assign bus.host_high_data_lanes_h = high_q;
    assign bus.host_data_oe_h = oe_q;
    assign cmd_ready_o = ready_q;
    assign rsp_valid_o = rsp_q;
    assign rsp_rdata_o = rdata_q;
    assign irq_n_o = irq_q;
endmodule
`default_nettype wire

// [tb/hpp_checker.sv]
// Concurrent checks on the wires between the host and device ends
`timescale 1ns/1ps
`default_nettype none
module hpp_checker (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // Interface signals
    input wire logic multiplex_select_strap,
    input wire logic chip_select_n,
    input wire logic write_strobe_n,
    input wire logic read_strobe_n,
    input wire logic address_latch_strobe,
    input wire logic [7:0] host_address_bus,
    input wire logic host_data_oe_d,
    input wire logic cycle_wait_out,
    input wire logic interrupt_out_n_o,
    input wire logic interrupt_out_n_oe
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    // ==========================================================
    // Properties
    property p_cs_wait; chip_select_n |-> !cycle_wait_out; endproperty
    a_cs_wait: assert property (p_cs_wait) else $error("wait without select");
    property p_wait_start;
        !chip_select_n && ($fell(write_strobe_n) || $fell(read_strobe_n)) |-> ##[1:4] cycle_wait_out;
    endproperty
    a_wait_start: assert property (p_wait_start) else $error("no wait after strobe");
    property p_wait_len;
        $rose(cycle_wait_out) |-> cycle_wait_out[*2] ##[1:2] !cycle_wait_out;
    endproperty
    a_wait_len: assert property (p_wait_len) else $error("wait length wrong");
    property p_oe_read;
        $rose(host_data_oe_d) |-> !chip_select_n && !read_strobe_n && write_strobe_n
            && !cycle_wait_out;
    endproperty
    a_oe_read: assert property (p_oe_read) else $error("lanes driven outside a read");
    property p_write_quiet; !write_strobe_n |-> !host_data_oe_d; endproperty
    a_write_quiet: assert property (p_write_quiet) else $error("lanes driven in write");
    property p_hold;
        cycle_wait_out |=> !chip_select_n && $stable(host_address_bus);
    endproperty
    a_hold: assert property (p_hold) else $error("cycle not held in wait");
    property p_ale; address_latch_strobe |-> multiplex_select_strap; endproperty
    a_ale: assert property (p_ale) else $error("latch strobe in separate mode");
    property p_irq_od; interrupt_out_n_oe |-> !interrupt_out_n_o; endproperty
    a_irq_od: assert property (p_irq_od) else $error("interrupt pin driven high");
    // Reset is checked with no disable, since it is the reset itself under test
    property p_reset;
        disable iff (1'b0)
        !rst_n_i ##1 !rst_n_i |-> !cycle_wait_out && !host_data_oe_d && !interrupt_out_n_oe;
    endproperty
    a_reset: assert property (p_reset) else $error("outputs active in reset");
endmodule
`default_nettype wire

// [tb/host_parallel_register_port_tb.sv]
// Testbench joining host and device ends of the parallel port
`timescale 1ns/1ps
`default_nettype none
module host_parallel_register_port_tb;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic wide = 1'b0;
    logic mux = 1'b0;
    logic cmd_valid = 1'b0;
    logic cmd_write = 1'b0;
    logic cmd_boundary = 1'b0;
    logic [7:0] cmd_addr = 8'h00;
    logic [15:0] cmd_wdata = 16'h0000;
    logic [7:0] irq_src = 8'h00;
    logic cmd_ready, rsp_valid, irq_n, irq_pending;
    logic [15:0] rsp_rdata;
    logic [7:0] last_addr;
    int fail_count = 0;
    int total_checks = 0;
    hpp_if bus ();
    hpp_host i_hpp_host (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .wide_i(wide), .mux_i(mux),
        .cmd_valid_i(cmd_valid), .cmd_write_i(cmd_write), .cmd_boundary_i(cmd_boundary),
        .cmd_addr_i(cmd_addr), .cmd_wdata_i(cmd_wdata), .cmd_ready_o(cmd_ready),
        .rsp_valid_o(rsp_valid), .rsp_rdata_o(rsp_rdata), .irq_n_o(irq_n), .bus(bus));
    hpp_device i_hpp_device (.clk_sys_i(clk_sys_i), .master_reset_n_i(rst_n_i), .bus(bus),
        .irq_src_i(irq_src), .irq_pending_o(irq_pending), .last_addr_o(last_addr));
    hpp_checker i_hpp_checker (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .multiplex_select_strap(bus.multiplex_select_strap), .chip_select_n(bus.chip_select_n),
        .write_strobe_n(bus.write_strobe_n), .read_strobe_n(bus.read_strobe_n),
        .address_latch_strobe(bus.address_latch_strobe), .host_address_bus(bus.host_address_bus),
        .host_data_oe_d(bus.host_data_oe_d), .cycle_wait_out(bus.cycle_wait_out),
        .interrupt_out_n_o(bus.interrupt_out_n_o), .interrupt_out_n_oe(bus.interrupt_out_n_oe));
    initial begin
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: %s got %h want %h", $time, what, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // One access; outputs are read at the edge, before that edge's updates land
    task automatic acc(input logic w, b, input logic [7:0] a, input logic [15:0] d,
        output logic [15:0] r);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        while (cmd_ready !== 1'b1 && n < 60) begin
            @(posedge clk_sys_i);
            n++;
        end
        cmd_valid <= 1'b1;
        cmd_write <= w;
        cmd_boundary <= b;
        cmd_addr <= a;
        cmd_wdata <= d;
        @(posedge clk_sys_i);
        cmd_valid <= 1'b0;
        while (rsp_valid !== 1'b1 && n < 60) begin
            @(posedge clk_sys_i);
            n++;
        end
        r = rsp_rdata;
        chk(n < 60, 1'b1, "access finished");
    endtask
    function automatic logic [15:0] piece(logic [31:0] q, logic w, int i);
        return w ? q[31-16*i -: 16] : {8'h00, q[31-8*i -: 8]};
    endfunction
    task automatic await_irq(input logic v);
        int n;
        for (n = 0; n < 20 && irq_n !== v; n++) @(posedge clk_sys_i);
        chk(irq_n, v, "interrupt line");
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_modes();
        logic [31:0] q;
        logic [15:0] r;
        int n;
        for (int m = 0; m < 4; m++) begin
            @(posedge clk_sys_i);
            wide <= m[0];
            mux <= m[1];
            q = 32'hc3a5_1e70 ^ {4{8'(m)}};
            n = m[0] ? 2 : 4;
            for (int i = 0; i < n; i++) acc(1'b1, i == n - 1, 8'(16 + 4 * m), piece(q, m[0], i), r);
            for (int i = 0; i < n; i++) begin
                acc(1'b0, i == 0, 8'(16 + 4 * m), 16'h0000, r);
                chk(m[0] ? r : {8'h00, r[7:0]}, piece(q, m[0], i), "quadlet");
                chk(last_addr, 8'(16 + 4 * m), "last address");
            end
        end
        $display("test modes done");
    endtask
    task automatic t_irq();
        logic [15:0] r;
        @(posedge clk_sys_i);
        wide <= 1'b0;
        mux <= 1'b0;
        irq_src <= 8'h24;
        @(posedge clk_sys_i);
        irq_src <= 8'h00;
        await_irq(1'b0);
        chk(irq_pending, 1'b1, "pending");
        for (int i = 0; i < 4; i++) begin
            acc(1'b0, i == 0, 8'hfc, 16'h0000, r);
            chk(r[7:0], i == 3 ? 8'h24 : 8'h00, "cause");
        end
        for (int i = 0; i < 4; i++) acc(1'b1, i == 3, 8'hfc, i == 3 ? 16'h0024 : 16'h0000, r);
        await_irq(1'b1);
        $display("test interrupt done");
    endtask
    initial begin
        repeat (20) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        t_modes();
        t_irq();
        print_verdict();
    end
    // Whole run needs well under 1000 cycles
    initial begin
        #50us;
        fail_count++;
        $display("mismatch at %0t: run timed out", $time);
        print_verdict();
    end
endmodule
`default_nettype wire
